// file: ast_params.svh
// Register map, field positions, reset values and counts of the serial port
`ifndef AST_PARAMS_SVH
`define AST_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define AST_OFF_STATUS   3'h0
`define AST_OFF_CTRL_ONE 3'h1
`define AST_OFF_CTRL_TWO 3'h2
`define AST_OFF_DIVISOR  3'h3
`define AST_OFF_DATA     3'h4

// ----------------------------------------------------------------------
// Status bits
// ----------------------------------------------------------------------
`define AST_ST_PERR  7
`define AST_ST_NOISE 6
`define AST_ST_FERR  5
`define AST_ST_OERR  4
`define AST_ST_RIDLE 3
`define AST_ST_RXAV  2
`define AST_ST_TIDLE 1
`define AST_ST_TXE   0

// ----------------------------------------------------------------------
// Control one bits
// ----------------------------------------------------------------------
`define AST_C1_MASTER 7
`define AST_C1_WLEN   6
`define AST_C1_PEN    5
`define AST_C1_PODD   4
`define AST_C1_STOP2  3
`define AST_C1_RX9    2
`define AST_C1_BRK    1
`define AST_C1_TX9    0

// ----------------------------------------------------------------------
// Control two bits
// ----------------------------------------------------------------------
`define AST_C2_TXEN  7
`define AST_C2_RXEN  6
`define AST_C2_HIGH  5
`define AST_C2_TIIE  1
`define AST_C2_TEIE  0

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define AST_RST_CTRL_ONE 8'h00
`define AST_RST_CTRL_TWO 8'h00
`define AST_RST_DIVISOR  8'h00
`define AST_PRE_LOW      6'h3f
`define AST_PRE_HIGH     6'h0f
`define AST_BITS_8_LAST  4'h7
`define AST_BITS_9_LAST  4'h8
`define AST_STOP_1_LAST  4'h0
`define AST_STOP_2_LAST  4'h1

`endif

// file: ast_pkg.sv
// Types shared by the serial port modules
package ast_pkg;

   typedef enum logic [2:0]
   {
      ST_IDLE,
      ST_PEND,
      ST_START,
      ST_DATA,
      ST_STOP
   } ast_tx_state_t;

endpackage : ast_pkg

// file: ast_baud_if.sv
// Link between the transmitter core and its baud generator
`timescale 1ns/1ns
`default_nettype none

interface ast_baud_if #(parameter int DIV_W = 8);
   logic             run;
   logic             high_speed;
   logic [DIV_W-1:0] divisor;
   logic             tick;

   modport gen  (input run, input high_speed, input divisor, output tick);
   modport core (output run, output high_speed, output divisor, input tick);
endinterface : ast_baud_if

`default_nettype wire

// file: ast_baud_gen.sv
// Baud generator: one tick per bit period
`timescale 1ns/1ns
`default_nettype none

`include "ast_params.svh"

module ast_baud_gen
   import ast_pkg::*;
#(
   parameter int DIV_W = 8
)
(
   // Clock and reset
   input  wire logic  i_sys_clk,
   input  wire logic  i_rst,
   // Core side
   ast_baud_if.gen    bif
);

   logic [5:0]       pre_ff;
   logic [5:0]       nxt_pre;
   logic [DIV_W-1:0] cnt_ff;
   logic [DIV_W-1:0] nxt_cnt;

   wire logic [5:0] pre_last  = bif.high_speed ? `AST_PRE_HIGH : `AST_PRE_LOW;
   wire logic       pre_end   = (pre_ff == pre_last);
   wire logic       cnt_end   = (cnt_ff == bif.divisor);

   // Period is prescale times (divisor plus one); held clear when stopped
   // so every frame starts a fresh full period
   assign bif.tick = bif.run & pre_end & cnt_end;
   assign nxt_pre  = (!bif.run || pre_end) ? 6'h00 : pre_ff + 6'h01;
   assign nxt_cnt  = (!bif.run || (pre_end && cnt_end)) ? '0 :
                     (pre_end ? cnt_ff + 1'b1 : cnt_ff);

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         pre_ff <= 6'h00;
         cnt_ff <= '0;
      end
      else
      begin
         pre_ff <= nxt_pre;
         cnt_ff <= nxt_cnt;
      end
   end

endmodule : ast_baud_gen

`default_nettype wire

// file: ast_tx_top.sv
// Serial port transmitter, format control and register file
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

`include "ast_params.svh"

module ast_tx_top
   import ast_pkg::*;
#(
   parameter int DIV_W = 8
)
(
   // Clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst,
   // Register port
   input  wire logic [2:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   // Serial pins
   output logic            o_serial_out,
   output logic            o_serial_out_oe,
   output logic            o_serial_in_sel,
   // Interrupt request
   output logic            o_irq
);

   // ----------------------------------------------------------------------
   // Parity and word assembly
   // ----------------------------------------------------------------------
   function automatic logic [8:0] ast_frame_word(
      input logic [7:0] data,
      input logic       ninth,
      input logic       wlen9,
      input logic       pen,
      input logic       podd
   );
      logic [8:0] w;
      w = {ninth, data};
      if (pen)
      begin
         // Parity takes the MSB slot, computed over payload only
         if (wlen9)
            w[8] = (^data) ^ podd;
         else
            w[7] = (^data[6:0]) ^ podd;
      end
      return w;
   endfunction : ast_frame_word

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   ast_tx_state_t state_ff;
   ast_tx_state_t nxt_state;
   logic [7:0]    ctrl1_ff;
   logic [7:0]    nxt_ctrl1;
   logic [7:0]    ctrl2_ff;
   logic [7:0]    nxt_ctrl2;
   logic [7:0]    div_ff;
   logic [7:0]    nxt_div;
   logic [8:0]    shift_ff;
   logic [8:0]    nxt_shift;
   logic [8:0]    hold_ff;
   logic [8:0]    nxt_hold;
   logic          hold_valid_ff;
   logic          nxt_hold_valid;
   logic [3:0]    cnt_ff;
   logic [3:0]    nxt_cnt;
   logic          line_ff;
   logic          nxt_line;
   logic          txe_ff;
   logic          nxt_txe;
   logic          tidle_ff;
   logic          nxt_tidle;
   logic          armed_ff;
   logic          nxt_armed;
   logic [7:0]    rdata_ff;
   logic [7:0]    nxt_rdata;
   logic          irq_ff;
   logic          nxt_irq;

   ast_baud_if #(.DIV_W(DIV_W)) bif ();

   // ----------------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------------
   wire logic sel_stat  = (i_addr == `AST_OFF_STATUS);
   wire logic sel_c1    = (i_addr == `AST_OFF_CTRL_ONE);
   wire logic sel_c2    = (i_addr == `AST_OFF_CTRL_TWO);
   wire logic sel_div   = (i_addr == `AST_OFF_DIVISOR);
   wire logic sel_data  = (i_addr == `AST_OFF_DATA);

   wire logic master    = ctrl1_ff[`AST_C1_MASTER];
   wire logic tx_run    = master & ctrl2_ff[`AST_C2_TXEN];
   wire logic busy      = (state_ff == ST_START) |
                          (state_ff == ST_DATA) |
                          (state_ff == ST_STOP);
   wire logic data_wr   = i_wr & sel_data;
   // Write only after a status read and with the holding register free
   wire logic data_take = data_wr & master & txe_ff & armed_ff;

   // One format for both directions
   wire logic wlen9     = ctrl1_ff[`AST_C1_WLEN];
   wire logic two_stop  = ctrl1_ff[`AST_C1_STOP2];
   wire logic [8:0] word_in = ast_frame_word(i_wdata,
                                             ctrl1_ff[`AST_C1_TX9],
                                             wlen9,
                                             ctrl1_ff[`AST_C1_PEN],
                                             ctrl1_ff[`AST_C1_PODD]);
   wire logic [3:0] data_last = wlen9 ? `AST_BITS_9_LAST
                                      : `AST_BITS_8_LAST;
   wire logic [3:0] stop_last = two_stop ? `AST_STOP_2_LAST
                                         : `AST_STOP_1_LAST;

   // Receive side is idle with no flags while the receiver is not built in
   wire logic [7:0] status_word = {1'b0, 1'b0, 1'b0, 1'b0,
                                   1'b1, 1'b0, tidle_ff, txe_ff};

   // ----------------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------------
   always_comb
   begin
      nxt_ctrl1 = ctrl1_ff;
      nxt_ctrl2 = ctrl2_ff;
      nxt_div   = div_ff;
      if (i_wr && sel_c1)
      begin
         nxt_ctrl1 = i_wdata;
         nxt_ctrl1[`AST_C1_RX9] = ctrl1_ff[`AST_C1_RX9];
      end
      if (i_wr && sel_c2)
         nxt_ctrl2 = i_wdata;
      if (i_wr && sel_div)
         nxt_div = i_wdata;
      // Disabled port drops transmit and receive enables and break, keeps format and rate
      if (!nxt_ctrl1[`AST_C1_MASTER])
      begin
         nxt_ctrl1[`AST_C1_BRK]  = 1'b0;
         nxt_ctrl2[`AST_C2_TXEN] = 1'b0;
         nxt_ctrl2[`AST_C2_RXEN] = 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Transmitter
   // ----------------------------------------------------------------------
   always_comb
   begin
      nxt_state      = state_ff;
      nxt_shift      = shift_ff;
      nxt_hold       = hold_ff;
      nxt_hold_valid = hold_valid_ff;
      nxt_cnt        = cnt_ff;
      nxt_txe        = txe_ff;
      nxt_tidle      = tidle_ff;

      if (data_take)
      begin
         nxt_tidle = 1'b0;
         if (state_ff == ST_IDLE)
         begin
            // Straight into the shifter; the empty flag stays set
            nxt_shift = word_in;
            nxt_state = ST_PEND;
         end
         else
         begin
            nxt_hold       = word_in;
            nxt_hold_valid = 1'b1;
            nxt_txe        = 1'b0;
         end
      end

      unique case (state_ff)
         ST_IDLE:
            ;
         ST_PEND:
         begin
            // A preloaded word waits here until the transmitter is enabled
            if (tx_run)
               nxt_state = ST_START;
         end
         ST_START:
         begin
            if (bif.tick)
            begin
               nxt_state = ST_DATA;
               nxt_cnt   = data_last;
            end
         end
         ST_DATA:
         begin
            if (bif.tick)
            begin
               if (cnt_ff == 4'h0)
               begin
                  nxt_state = ST_STOP;
                  nxt_cnt   = stop_last;
               end
               else
               begin
                  nxt_shift = {1'b1, shift_ff[8:1]};
                  nxt_cnt   = cnt_ff - 4'h1;
               end
            end
         end
         ST_STOP:
         begin
            if (bif.tick)
            begin
               if (cnt_ff == 4'h0)
               begin
                  // Set wins over a clear in the same cycle
                  nxt_tidle = 1'b1;
                  if (nxt_hold_valid)
                  begin
                     // Reload only after the last stop bit is out
                     nxt_shift      = nxt_hold;
                     nxt_hold_valid = 1'b0;
                     nxt_txe        = 1'b1;
                     nxt_state      = ST_START;
                  end
                  else
                     nxt_state = ST_IDLE;
               end
               else
                  nxt_cnt = cnt_ff - 4'h1;
            end
         end
      endcase

      // Transmit enable dropped mid-frame resets the transmitter
      if (busy && !tx_run)
      begin
         nxt_state      = ST_IDLE;
         nxt_hold_valid = 1'b0;
         nxt_txe        = 1'b1;
         nxt_tidle      = 1'b1;
      end

      // Master disable empties everything and aborts at once
      if (!master)
      begin
         nxt_state      = ST_IDLE;
         nxt_hold_valid = 1'b0;
         nxt_txe        = 1'b1;
         nxt_tidle      = 1'b1;
      end
   end

   // Line level follows the state being entered; high outside frames
   assign nxt_line = (nxt_state == ST_START) ? 1'b0 :
                     (nxt_state == ST_DATA)  ? nxt_shift[0] :
                     1'b1;

   // ----------------------------------------------------------------------
   // Read side and interrupt
   // ----------------------------------------------------------------------
   // Status read arms the flag clear; any data write or disable disarms
   assign nxt_armed = !master ? 1'b0 :
                      (i_rd && sel_stat) ? 1'b1 :
                      data_wr ? 1'b0 : armed_ff;

   assign nxt_rdata = !i_rd    ? 8'h00 :
                      sel_stat ? status_word :
                      sel_c1   ? ctrl1_ff :
                      sel_c2   ? ctrl2_ff :
                      sel_div  ? div_ff :
                      8'h00;

   assign nxt_irq = master &
                    ((ctrl2_ff[`AST_C2_TEIE] & txe_ff) |
                     (ctrl2_ff[`AST_C2_TIIE] & tidle_ff));

   // ----------------------------------------------------------------------
   // Baud generator
   // ----------------------------------------------------------------------
   // Runs only during a frame so each start bit gets a full period
   assign bif.run        = busy & tx_run;
   assign bif.high_speed = ctrl2_ff[`AST_C2_HIGH];
   assign bif.divisor    = div_ff;

   ast_baud_gen #(.DIV_W(DIV_W)) u_baud (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .bif       (bif.gen)
   );

   // ----------------------------------------------------------------------
   // Flip-flops
   // ----------------------------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         ctrl1_ff <= `AST_RST_CTRL_ONE;
         ctrl2_ff <= `AST_RST_CTRL_TWO;
         div_ff   <= `AST_RST_DIVISOR;
      end
      else
      begin
         ctrl1_ff <= nxt_ctrl1;
         ctrl2_ff <= nxt_ctrl2;
         div_ff   <= nxt_div;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         state_ff      <= ST_IDLE;
         shift_ff      <= 9'h1ff;
         hold_ff       <= 9'h000;
         hold_valid_ff <= 1'b0;
         cnt_ff        <= 4'h0;
         line_ff       <= 1'b1;
         txe_ff        <= 1'b1;
         tidle_ff      <= 1'b1;
      end
      else
      begin
         state_ff      <= nxt_state;
         shift_ff      <= nxt_shift;
         hold_ff       <= nxt_hold;
         hold_valid_ff <= nxt_hold_valid;
         cnt_ff        <= nxt_cnt;
         line_ff       <= nxt_line;
         txe_ff        <= nxt_txe;
         tidle_ff      <= nxt_tidle;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         armed_ff <= 1'b0;
         rdata_ff <= 8'h00;
         irq_ff   <= 1'b0;
      end
      else
      begin
         armed_ff <= nxt_armed;
         rdata_ff <= nxt_rdata;
         irq_ff   <= nxt_irq;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign o_rdata         = rdata_ff;
   assign o_serial_out    = line_ff;
   assign o_serial_out_oe = tx_run;
   assign o_serial_in_sel = master & ctrl2_ff[`AST_C2_RXEN];
   assign o_irq           = irq_ff;

endmodule : ast_tx_top

`default_nettype wire

// file: ast_tx_properties.sv
// Concurrent checks on the serial port top-level ports
`timescale 1ns/1ns
`default_nettype none

module ast_tx_properties #(parameter int DIV_W = 8)
(
   // Clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst,
   // Register port
   input  wire logic [2:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic [7:0] o_rdata,
   // Pins and interrupt
   input  wire logic       o_serial_out,
   input  wire logic       o_serial_out_oe,
   input  wire logic       o_serial_in_sel,
   input  wire logic       o_irq
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   // ----
   // Shadow of control bits, rebuilt from the writes
   // ----
   logic             m_ff;
   logic [7:0]       c2_ff;
   logic [DIV_W-1:0] div_ff;
   logic [15:0]      run_ff;
   logic [15:0]      per;
   wire              w1 = i_wr && i_addr == 3'h1;
   wire              w2 = i_wr && i_addr == 3'h2;
   assign per = (c2_ff[5] ? 16'h10 : 16'h40) * (16'(div_ff) + 16'h1);

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         m_ff <= 1'b0;
         c2_ff <= 8'h00;
         div_ff <= '0;
      end
      else
      begin
         if (w1)
            m_ff <= i_wdata[7];
         if (w2)
            c2_ff <= {i_wdata[7:6] & {2{m_ff}}, i_wdata[5:0]};
         else if (w1 && !i_wdata[7])
            c2_ff <= {2'b00, c2_ff[5:0]};
         if (i_wr && i_addr == 3'h3)
            div_ff <= i_wdata[DIV_W-1:0];
      end
   end

   // Length of the present low run on the line
   always_ff @(posedge i_sys_clk)
      run_ff <= (i_rst || o_serial_out) ? 16'h0 : run_ff + 16'h1;

   // ----
   // Sequences and properties
   // ----
   sequence s_master_off;
      w1 && !i_wdata[7];
   endsequence
   sequence s_tx_off;
      w2 && !i_wdata[7];
   endsequence
   sequence s_released;
      !o_serial_out_oe ##1 o_serial_out;
   endsequence

   property p_idle_high;
      !o_serial_out_oe && !$past(o_serial_out_oe) |-> o_serial_out;
   endproperty
   property p_pins;
      o_serial_out_oe == (m_ff && c2_ff[7]) &&
      o_serial_in_sel == (m_ff && c2_ff[6]);
   endproperty
   property p_master_off;
      s_master_off |=> s_released and !o_serial_in_sel;
   endproperty
   property p_tx_off;
      s_tx_off |=> s_released;
   endproperty
   property p_status_rx;
      i_rd && i_addr == 3'h0 |=> o_rdata[7:3] == 5'h01;
   endproperty
   property p_keep_div;
      i_rd && i_addr == 3'h3 |=> o_rdata == 8'(div_ff);
   endproperty
   property p_keep_c2;
      i_rd && i_addr == 3'h2 |=> o_rdata == c2_ff;
   endproperty
   property p_period;
      $rose(o_serial_out) && o_serial_out_oe |->
         run_ff != 16'h0 && run_ff % per == 16'h0;
   endproperty
   property p_irq_off;
      !m_ff && !$past(m_ff) |-> !o_irq;
   endproperty

   a_idle_high: assert property (p_idle_high)
      else $error("line low while not driven");
   a_pins: assert property (p_pins)
      else $error("pin ownership wrong");
   a_master_off: assert property (p_master_off)
      else $error("disable did not release pins");
   a_tx_off: assert property (p_tx_off)
      else $error("transmit disable did not stop line");
   a_status_rx: assert property (p_status_rx)
      else $error("receive status bits wrong");
   a_keep_div: assert property (p_keep_div)
      else $error("divisor not kept");
   a_keep_c2: assert property (p_keep_c2)
      else $error("control two not kept");
   a_period: assert property (p_period)
      else $error("low run not whole bit periods");
   a_irq_off: assert property (p_irq_off)
      else $error("interrupt while disabled");
endmodule : ast_tx_properties

bind ast_tx_top ast_tx_properties #(.DIV_W(DIV_W)) i_props
(
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_serial_out(o_serial_out), .o_serial_out_oe(o_serial_out_oe),
   .o_serial_in_sel(o_serial_in_sel), .o_irq(o_irq)
);

`default_nettype wire

// file: ast_remote_rx.sv
// Far-side receiver model that decodes frames from the serial output
`timescale 1ns/1ns
`default_nettype none

module ast_remote_rx
(
   // Clock
   input  wire logic        i_sys_clk,
   // Line and format
   input  wire logic        i_line,
   input  wire logic        i_oe,
   input  wire logic [15:0] i_per,
   input  wire logic [3:0]  i_nbits,
   input  wire logic [1:0]  i_nstop,
   // Decoded frame
   output var  logic [8:0]  o_word,
   output var  logic        o_stop_ok,
   output var  int          o_cnt
);
   logic [8:0] w;
   logic       s;

   initial
   begin
      o_word = 9'h000;
      o_stop_ok = 1'b0;
      o_cnt = 0;
   end

   // Samples mid-bit, so a drift of under half a bit across the whole frame still decodes
   always
   begin
      @(negedge i_line iff i_oe);
      repeat (i_per / 2) @(posedge i_sys_clk);
      w = 9'h000;
      s = 1'b1;
      for (int k = 0; k < i_nbits; k++)
      begin
         repeat (i_per) @(posedge i_sys_clk);
         w[k] = i_line;
      end
      for (int k = 0; k < i_nstop; k++)
      begin
         repeat (i_per) @(posedge i_sys_clk);
         s = s & i_line;
      end
      o_word = w;
      o_stop_ok = s;
      o_cnt = o_cnt + 1;
   end
endmodule : ast_remote_rx

`default_nettype wire

// file: async_serial_tx_and_format_control_tb_top.sv
// Self-checking testbench of the serial transmitter and format control
`timescale 1ns/1ns
`default_nettype none

module async_serial_tx_and_format_control_tb_top;
   logic        clk;
   logic        rst;
   logic [2:0]  addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata;
   logic        so;
   logic        oe;
   logic        isel;
   logic        irq;
   logic [15:0] per;
   logic [3:0]  nb;
   logic [1:0]  ns;
   logic [8:0]  rx_word;
   logic        rx_stop;
   logic [8:0]  e;
   int          rx_cnt;
   int          miscompares;
   int          n_compared;
   int          t;
   logic [7:0]  cfg [6] = '{8'h80, 8'ha8, 8'hb0, 8'hc1, 8'he1, 8'hf9};
   logic [7:0]  dat [6] = '{8'ha5, 8'h13, 8'h13, 8'h3c, 8'hff, 8'h01};

   ast_tx_top i_dut
   (
      .i_sys_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_serial_out(so),
      .o_serial_out_oe(oe), .o_serial_in_sel(isel), .o_irq(irq)
   );
   ast_remote_rx i_peer
   (
      .i_sys_clk(clk), .i_line(so), .i_oe(oe), .i_per(per), .i_nbits(nb),
      .i_nstop(ns), .o_word(rx_word), .o_stop_ok(rx_stop), .o_cnt(rx_cnt)
   );

   // ----
   // Bus and checking tasks
   // ----
   task automatic final_report();
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Strobes drop after each edge; a following call raises them again
   task automatic bus(input logic w, input logic r, input logic [2:0] a,
                      input logic [7:0] d);
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
   endtask : bus

   task automatic rdc(input logic [2:0] a, input logic [7:0] x);
      bus(1'b0, 1'b1, a, 8'h00);
      chk({8'h00, rdata}, {8'h00, x});
   endtask : rdc

   task automatic send(input logic [7:0] d);
      bus(1'b0, 1'b1, 3'h0, 8'h00);
      bus(1'b1, 1'b0, 3'h4, d);
   endtask : send

   task automatic wait_frame(input int n);
      int k;
      for (k = 0; k < 40000 && rx_cnt < n; k++)
         @(posedge clk);
      if (rx_cnt < n)
      begin
         miscompares++;
         final_report();
      end
   endtask : wait_frame

   // Counts clocks while the line stays at lvl; a stuck line ends the run
   task automatic hold_len(input logic lvl, output int n);
      for (n = 0; n < 300 && so === lvl; n++)
         @(posedge clk);
      if (n >= 300)
      begin
         miscompares++;
         final_report();
      end
   endtask : hold_len

   function automatic logic [8:0] exp_word(input logic [7:0] c,
                                           input logic [7:0] d);
      logic [8:0] w;
      w = {c[6] & c[0], d};
      if (c[5] && c[6])
         w[8] = ^d ^ c[4];
      else if (c[5])
         w[7] = ^d[6:0] ^ c[4];
      return w;
   endfunction : exp_word

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ----
   // Main sequence
   // ----
   initial
   begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 3'h0;
      wdata = 8'h00;
      per = 16'h10;
      nb = 4'h8;
      ns = 2'h1;
      miscompares = 0;
      n_compared = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdc(3'h0, 8'h0b);
      rdc(3'h1, 8'h00);
      rdc(3'h2, 8'h00);
      rdc(3'h7, 8'h00);
      chk({14'h0, oe, so}, 16'h1);
      bus(1'b1, 1'b0, 3'h1, 8'h80);
      bus(1'b1, 1'b0, 3'h2, 8'ha0);
      // Data write with no status read first must be dropped
      bus(1'b1, 1'b0, 3'h4, 8'h55);
      repeat (4) @(posedge clk);
      rdc(3'h0, 8'h0b);
      for (int i = 0; i < 6; i++)
      begin
         bus(1'b1, 1'b0, 3'h1, cfg[i]);
         nb = cfg[i][6] ? 4'h9 : 4'h8;
         ns = cfg[i][3] ? 2'h2 : 2'h1;
         e = exp_word(cfg[i], dat[i]);
         send(dat[i]);
         wait_frame(i + 1);
         chk({7'h0, rx_word}, {7'h0, e});
         chk({15'h0, rx_stop}, 16'h1);
         repeat (40) @(posedge clk);
         rdc(3'h0, 8'h0b);
      end
      bus(1'b1, 1'b0, 3'h1, 8'h80);
      nb = 4'h8;
      ns = 2'h1;
      send(8'h11);
      rdc(3'h0, 8'h09);
      bus(1'b1, 1'b0, 3'h4, 8'h22);
      rdc(3'h0, 8'h08);
      bus(1'b1, 1'b0, 3'h4, 8'h33);
      wait_frame(7);
      chk({7'h0, rx_word}, 16'h0011);
      wait_frame(8);
      chk({7'h0, rx_word}, 16'h0022);
      repeat (400) @(posedge clk);
      chk(rx_cnt[15:0], 16'h8);
      rdc(3'h0, 8'h0b);
      bus(1'b1, 1'b0, 3'h2, 8'h80);
      bus(1'b1, 1'b0, 3'h3, 8'h01);
      per = 16'h80;
      send(8'h01);
      hold_len(1'b1, t);
      hold_len(1'b0, t);
      chk(t[15:0], 16'h80);
      wait_frame(9);
      chk({7'h0, rx_word}, 16'h0001);
      send(8'h00);
      repeat (300) @(posedge clk);
      bus(1'b1, 1'b0, 3'h2, 8'h00);
      bus(1'b0, 1'b0, 3'h0, 8'h00);
      chk({14'h0, oe, so}, 16'h1);
      rdc(3'h0, 8'h0b);
      // Word loaded before transmit enable waits with the line high
      send(8'h00);
      repeat (40) @(posedge clk);
      chk({14'h0, oe, so}, 16'h1);
      rdc(3'h0, 8'h09);
      bus(1'b1, 1'b0, 3'h2, 8'hc3);
      bus(1'b0, 1'b0, 3'h0, 8'h00);
      chk({13'h0, isel, irq, so}, 16'h6);
      repeat (300) @(posedge clk);
      bus(1'b1, 1'b0, 3'h1, 8'h00);
      bus(1'b0, 1'b0, 3'h0, 8'h00);
      chk({13'h0, oe, isel, so}, 16'h1);
      rdc(3'h0, 8'h0b);
      rdc(3'h2, 8'h03);
      rdc(3'h3, 8'h01);
      chk({15'h0, irq}, 16'h0);
      final_report();
   end
endmodule : async_serial_tx_and_format_control_tb_top

`default_nettype wire
